/* pcc_counter_ctrl.sv */
// comparator-clear of pwm outputs plus counter run, overflow and match flags
//
// Behaviour
// (R1) pwm modes: clear forces channel low this cycle
// (R2) comparator synchronised to system clock first
// (R3) clear enabled per channel by its bit
// (R4) disabled clear leaves pwm output untouched
// (R5) polarity 0: falling comparator edge forces low
// (R6) polarity 1: rising comparator edge forces low
// (R7) active level persists: next cycle stays low
// (R8) counter wrap ffff to 0 sets overflow
// (R9) enabled overflow flag raises interrupt request
// (R10) flags cleared only by software, never hardware
// (R11) run bit 0 stops, 1 runs counter
// (R12) bits 5 to 3 read zero, ignore writes
// (R13) module match or capture sets its flag
// (R14) enabled module flag raises interrupt request
// (R15) register at d8 on all pages, bit-addressable
// (R16) overflow request gated by overflow enable
// (R17) forced low ends at next cycle boundary
`timescale 1ns/10ps
module pcc_counter_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // special function register port, byte access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // special function register port, single bit access
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_wdata,
  // configuration held outside this block
  input wire pcc_pkg::pcc_clr_ctrl_s clr_ctrl,
  input wire logic overflow_irq_enable,
  input wire logic [2:0] module_irq_enable,
  // counter timebase and module events
  input wire logic count_tick,
  input wire logic [2:0] match_event,
  // pwm datapath
  input wire logic [2:0] pwm_mode_active,
  input wire logic [2:0] pwm_cycle_start,
  input wire logic [2:0] pwm_raw,
  // analog comparator, asynchronous
  input wire logic cmp_async,
  // results
  output logic [2:0] pwm_channel_output,
  output logic [15:0] counter_value,
  output logic irq
);

  // reset release synchroniser
  logic rst_s1_n;
  logic rst_sync_n;

  // assert at once, release after two edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_n <= 1'b1;
      rst_sync_n <= rst_s1_n;
    end
  end

  // decode of the register address, used by byte writes and reads
  function automatic logic csr_hit(input logic [7:0] addr);
    csr_hit = (addr == pcc_pkg::CSR_ADDR);
  endfunction : csr_hit

  // register state
  pcc_pkg::pcc_csr_s csr;       // flags and run bit
  pcc_pkg::pcc_csr_s next_csr;  // value for the next edge
  logic [7:0] wr_en;            // per bit software write enable
  logic [7:0] wr_val;           // per bit software write value
  logic wrap;                   // counter wraps this cycle

  // software write decode; byte and bit writes share one path
  always_comb begin
    wr_en = 8'h00;
    wr_val = sfr_wdata;
    if (sfr_wr && csr_hit(sfr_addr)) begin // R15
      wr_en = 8'hff;
    end else if (bit_wr && bit_addr[7:3] == pcc_pkg::CSR_BIT_BASE) begin // R15
      wr_en[bit_addr[2:0]] = 1'b1;
      wr_val = {8{bit_wdata}};
    end
  end

  // counter wraps only when running and ticking at the top value
  assign wrap = count_tick && csr.run && counter_value == pcc_pkg::CNT_MAX;

  // next register image; a hardware set wins over a software clear
  always_comb begin
    next_csr = csr;
    next_csr.unused = pcc_pkg::RSV_VALUE; // R12
    if (wr_en[pcc_pkg::RUN_BIT]) begin
      next_csr.run = wr_val[pcc_pkg::RUN_BIT];
    end
    // flags only change on a software write or a hardware set
    if (wr_en[pcc_pkg::CF_BIT]) begin // R10
      next_csr.cf = wr_val[pcc_pkg::CF_BIT];
    end
    if (wrap) begin
      next_csr.cf = 1'b1; // R8
    end
    for (int i = 0; i < pcc_pkg::NUM_CH; i++) begin
      if (wr_en[pcc_pkg::CCF_LSB + i]) begin // R10
        next_csr.ccf[i] = wr_val[pcc_pkg::CCF_LSB + i];
      end
      if (match_event[i]) begin
        next_csr.ccf[i] = 1'b1; // R13
      end
    end
  end

  // control/status register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      csr <= pcc_pkg::CSR_RESET;
    end else begin
      csr <= next_csr;
    end
  end

  // the 16-bit counter; it wraps to zero, and the wrap sets the overflow flag
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      counter_value <= pcc_pkg::CNT_RESET;
    end else if (count_tick && csr.run) begin // R11
      counter_value <= counter_value + 16'h0001;
    end
  end

  // interrupt request follows the next flags so it rises with them
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (next_csr.cf && overflow_irq_enable) // R9 R16
        || |(next_csr.ccf & module_irq_enable); // R14
    end
  end

  // read port; reserved bits come back as zero from the struct
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= pcc_pkg::RDATA_IDLE;
    end else if (sfr_rd && csr_hit(sfr_addr)) begin // R15
      sfr_rdata <= csr; // R12
    end else begin
      sfr_rdata <= pcc_pkg::RDATA_IDLE;
    end
  end

  // comparator synchroniser; cmp_s1 feeds only cmp_s2
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;   // previous synchronised value for edge detect
  logic cmp_fall; // falling edge of synchronised comparator
  logic cmp_rise; // rising edge of synchronised comparator
  logic cmp_edge; // edge selected by polarity
  logic cmp_level;// comparator at its active level

  // two flops against metastability, one more to see edges
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
    end else begin
      cmp_s1 <= cmp_async; // R2
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
    end
  end

  // the edge flop holds its reset value, not a sample, for the first cycles;
  // without this a comparator idling high would look like a rising edge after reset
  logic [2:0] cmp_fill; // ones shift in behind the synchroniser chain
  logic cmp_live;       // whole chain carries live comparator samples

  // fill marker, full once the edge flop has taken a real sample
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmp_fill <= 3'h0;
    end else begin
      cmp_fill <= {cmp_fill[1:0], 1'b1};
    end
  end

  assign cmp_live = cmp_fill[2];
  assign cmp_fall = cmp_live && cmp_s3 && !cmp_s2; // R5
  assign cmp_rise = cmp_live && !cmp_s3 && cmp_s2; // R6
  // polarity picks the edge and the level that keeps the clear alive
  assign cmp_edge = clr_ctrl.polarity ? cmp_rise : cmp_fall; // R5 R6
  assign cmp_level = clr_ctrl.polarity ? cmp_s2 : !cmp_s2; // R7

  // per channel clear hold and output stage
  logic [2:0] clear_hold;
  logic [2:0] next_hold;

  for (genvar g = 0; g < pcc_pkg::NUM_CH; g++) begin : g_ch
    // hold recomputed at each boundary; an edge on the boundary still sets it
    always_comb begin
      if (!clr_ctrl.enable[g] || !pwm_mode_active[g]) begin
        next_hold[g] = 1'b0; // R3 R4
      end else if (cmp_edge) begin
        next_hold[g] = 1'b1; // R1 R5 R6
      end else if (pwm_cycle_start[g]) begin
        next_hold[g] = cmp_level; // R7 R17
      end else begin
        next_hold[g] = clear_hold[g];
      end
    end

    // hold flop
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        clear_hold[g] <= 1'b0;
      end else begin
        clear_hold[g] <= next_hold[g];
      end
    end

    // output is registered, one cycle behind the raw pwm level
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pwm_channel_output[g] <= 1'b0;
      end else begin
        pwm_channel_output[g] <= pwm_raw[g] && !next_hold[g]; // R1 R4
      end
    end

    force_low_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R1
      clear_hold[g] |-> !pwm_channel_output[g])
      else $error("pwm output high while clear holds");

    disabled_pass_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R4
      (rst_sync_n && !clr_ctrl.enable[g]) |=> pwm_channel_output[g] == $past(pwm_raw[g]))
      else $error("disabled clear changed pwm output");

    rise_clear_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R6
      (clr_ctrl.polarity && clr_ctrl.enable[g] && pwm_mode_active[g] && cmp_rise)
      |=> !pwm_channel_output[g] && clear_hold[g])
      else $error("rising edge did not clear pwm output");

    fall_clear_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R5
      (!clr_ctrl.polarity && clr_ctrl.enable[g] && pwm_mode_active[g] && cmp_fall)
      |=> !pwm_channel_output[g] && clear_hold[g])
      else $error("falling edge did not clear pwm output");

    mode_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R1
      (rst_sync_n && !pwm_mode_active[g]) |=> !clear_hold[g] && pwm_channel_output[g] == $past(pwm_raw[g]))
      else $error("clear held outside pwm mode");

    level_carry_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R7
      (pwm_cycle_start[g] && clr_ctrl.enable[g] && pwm_mode_active[g] && cmp_level)
      |=> clear_hold[g])
      else $error("active level did not keep clear into next cycle");

    release_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R17
      (pwm_cycle_start[g] && !cmp_edge && !cmp_level) |=> !clear_hold[g])
      else $error("clear did not end at cycle boundary");

    match_set_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R13
      match_event[g] |=> csr.ccf[g] ##1 (csr.ccf[g] || $past(wr_en[pcc_pkg::CCF_LSB + g])))
      else $error("match event did not set module flag");
  end

  sync_fall_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R2 R5
    cmp_fall |-> $past(cmp_async, 3) && !$past(cmp_async, 2))
    else $error("falling edge not from synchronised comparator");

  ovf_set_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R8
    (count_tick && csr.run && counter_value == pcc_pkg::CNT_MAX)
    |=> csr.cf && counter_value == pcc_pkg::CNT_RESET)
    else $error("wrap did not set overflow flag");

  flag_sticky_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R10
    (csr.cf && !wr_en[pcc_pkg::CF_BIT]) |=> csr.cf)
    else $error("overflow flag cleared without software");

  run_stop_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R11
    !csr.run |=> $stable(counter_value))
    else $error("counter moved while stopped");

  ovf_irq_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R9 R16
    (csr.cf && $past(overflow_irq_enable)) |-> irq)
    else $error("overflow flag without interrupt request");

  mod_irq_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R14
    (|(csr.ccf & $past(module_irq_enable))) |-> irq)
    else $error("module flag without interrupt request");

  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R12
    sfr_rdata[pcc_pkg::RSV_HI:pcc_pkg::RSV_LO] == pcc_pkg::RSV_VALUE)
    else $error("reserved bits read nonzero");

  csr_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R15
    (sfr_rd && sfr_addr == pcc_pkg::CSR_ADDR) |=> sfr_rdata == $past(csr))
    else $error("register read returned wrong value");

endmodule : pcc_counter_ctrl

/* pcc_pkg.sv */
// package with constants and types of the pwm comparator-clear and counter control block
package pcc_pkg;
  // number of capture/compare modules and pwm channels
  localparam int unsigned NUM_CH = 3;
  // counter width and its top value
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // control/status register address, seen from every page
  localparam logic [7:0] CSR_ADDR = 8'hd8;
  // bit address block of the bit-addressable register (address bits 7:3)
  localparam logic [4:0] CSR_BIT_BASE = 5'h1b;
  // field positions inside the control/status register
  localparam int unsigned CF_BIT = 7;
  localparam int unsigned RUN_BIT = 6;
  localparam int unsigned RSV_HI = 5;
  localparam int unsigned RSV_LO = 3;
  localparam int unsigned CCF_LSB = 0;
  // reset value of the control/status register
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam logic [2:0] RSV_VALUE = 3'h0;

  // control/status register image as software sees it
  typedef struct packed {
    logic cf;             // counter overflow flag
    logic run;            // counter run bit
    logic [2:0] unused;   // always zero
    logic [2:0] ccf;      // module match/capture flags
  } pcc_csr_s;

  // comparator-clear controls for all channels
  typedef struct packed {
    logic [2:0] enable;   // per channel clear enable
    logic polarity;       // 0 falling edge, 1 rising edge
  } pcc_clr_ctrl_s;
endpackage : pcc_pkg

/* pcc_far_side.sv */
// far-side model: analog comparator and pwm datapath source
`timescale 1ns/10ps
module pcc_far_side #(
  parameter int PERIOD = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // comparator level asked for by the bench
  input wire logic cmp_level,
  // towards the block
  output logic cmp_async,
  output logic [2:0] pwm_cycle_start,
  output logic [2:0] pwm_raw
);
  // position inside the pwm period
  int phase;
  // comparator moves 7 ns off the edge, so it never changes on a clock edge
  assign #7 cmp_async = cmp_level;
  // period counter shared by all channels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 0;
    end else begin
      phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    end
  end
  // full duty keeps any forced low plainly visible
  assign pwm_cycle_start = (phase == 0) ? 3'h7 : 3'h0;
  assign pwm_raw = 3'h7;
endmodule : pcc_far_side

/* tb.sv */
// self-checking testbench for the comparator-clear and counter control block
`timescale 1ns/10ps
module tb;
  // design inputs, all valued at time zero
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] bit_addr = 8'h00;
  logic bit_wr = 1'b0;
  logic bit_wdata = 1'b0;
  pcc_pkg::pcc_clr_ctrl_s clr_ctrl = '0;
  logic overflow_irq_enable = 1'b0;
  logic [2:0] module_irq_enable = 3'h0;
  logic count_tick = 1'b0;
  logic [2:0] match_event = 3'h0;
  logic [2:0] pwm_mode_active = 3'h7;
  logic cmp_level = 1'b1;
  // outputs and far-side nets
  logic [7:0] sfr_rdata;
  logic [2:0] pwm_cycle_start;
  logic [2:0] pwm_raw;
  logic [2:0] pwm_channel_output;
  logic cmp_async;
  logic irq;
  logic [15:0] counter_value;
  // bookkeeping
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // 25 ns clock
  always #12.5 clock = ~clock;

  pcc_counter_ctrl dut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
    .bit_wr(bit_wr), .bit_wdata(bit_wdata), .clr_ctrl(clr_ctrl),
    .overflow_irq_enable(overflow_irq_enable), .module_irq_enable(module_irq_enable),
    .count_tick(count_tick), .match_event(match_event), .pwm_mode_active(pwm_mode_active),
    .pwm_cycle_start(pwm_cycle_start), .pwm_raw(pwm_raw), .cmp_async(cmp_async),
    .pwm_channel_output(pwm_channel_output), .counter_value(counter_value), .irq(irq));

  pcc_far_side #(.PERIOD(16)) far (.clock(clock), .rst_n(rst_n), .cmp_level(cmp_level),
    .cmp_async(cmp_async), .pwm_cycle_start(pwm_cycle_start), .pwm_raw(pwm_raw));

  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // one comparison
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // n edges, then let their updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // byte write, strobe for one edge
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    sfr_addr <= addr;
    sfr_wdata <= data;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  // single bit write; bit n sits at d8 plus n
  task automatic bit_write(input logic [2:0] n, input logic v);
    @(posedge clock);
    bit_addr <= {5'h1b, n};
    bit_wdata <= v;
    bit_wr <= 1'b1;
    @(posedge clock);
    bit_wr <= 1'b0;
  endtask : bit_write

  // byte read; data is registered, so it is taken just after the next edge
  task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= addr;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 check("register", sfr_rdata, exp);
  endtask : reg_check

  // exactly n counter ticks
  task automatic ticks(input int n);
    @(posedge clock);
    count_tick <= 1'b1;
    repeat (n) @(posedge clock);
    count_tick <= 1'b0;
    #1;
  endtask : ticks

  // align to the first edge of a pwm period, bounded
  task automatic wait_start();
    int i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pwm_cycle_start[0] !== 1'b1 && i < 40);
  endtask : wait_start

  // hang guard: the run needs roughly 66000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    // register map, reserved bits and unmapped address
    reg_check(8'hd8, 8'h00);
    sfr_write(8'hd8, 8'hff);
    reg_check(8'hd8, 8'hc7);
    sfr_write(8'hd9, 8'h00);
    reg_check(8'hd9, 8'h00);
    reg_check(8'hd8, 8'hc7);
    sfr_write(8'hd8, 8'h00);
    reg_check(8'hd8, 8'h00);
    // run bit through bit access, counting and stopping
    bit_write(3'h6, 1'b1);
    reg_check(8'hd8, 8'h40);
    ticks(10);
    check("counter", counter_value, 16'h000a);
    bit_write(3'h6, 1'b0);
    ticks(5);
    check("counter", counter_value, 16'h000a);
    // wrap from the top value sets overflow and the request
    bit_write(3'h6, 1'b1);
    overflow_irq_enable <= 1'b1;
    ticks(65525);
    check("counter", counter_value, 16'hffff);
    check("irq", irq, 1'b0);
    ticks(1);
    check("counter", counter_value, 16'h0000);
    check("irq", irq, 1'b1);
    reg_check(8'hd8, 8'hc0);
    @(posedge clock);
    overflow_irq_enable <= 1'b0;
    cyc(2);
    check("irq", irq, 1'b0);
    cyc(50);
    reg_check(8'hd8, 8'hc0);
    bit_write(3'h7, 1'b0);
    reg_check(8'hd8, 8'h40);
    // each module flag, its request, and software clear
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      match_event <= 3'(1 << i);
      module_irq_enable <= 3'(1 << i);
      @(posedge clock);
      match_event <= 3'h0;
      #1 check("irq", irq, 1'b1);
      reg_check(8'hd8, 8'h40 | 8'(1 << i));
      bit_write(3'(i), 1'b0);
      reg_check(8'hd8, 8'h40);
      check("irq", irq, 1'b0);
    end
    // hardware set and software clear in one cycle: the set wins
    @(posedge clock);
    match_event <= 3'h1;
    bit_addr <= {5'h1b, 3'h0};
    bit_wdata <= 1'b0;
    bit_wr <= 1'b1;
    @(posedge clock);
    match_event <= 3'h0;
    bit_wr <= 1'b0;
    reg_check(8'hd8, 8'h41);
    bit_write(3'h0, 1'b0);
    reg_check(8'hd8, 8'h40);
    // comparator clear on channels 0 and 1, channel 2 left disabled
    for (int p = 0; p < 2; p++) begin
      wait_start();
      clr_ctrl <= '{3'h3, p[0]};
      cmp_level <= ~p[0];
      wait_start();
      wait_start();
      cyc(3);
      check("pwm", pwm_channel_output, 3'h7);
      cmp_level <= p[0];
      cyc(6);
      check("pwm", pwm_channel_output, 3'h4);
      wait_start();
      cyc(3);
      check("pwm", pwm_channel_output, 3'h4);
      cmp_level <= ~p[0];
      wait_start();
      cyc(3);
      check("pwm", pwm_channel_output, 3'h7);
    end
    // leaving pwm mode drops a held clear at once
    cmp_level <= 1'b1;
    cyc(6);
    check("pwm", pwm_channel_output, 3'h4);
    pwm_mode_active <= 3'h6;
    cyc(2);
    check("pwm", pwm_channel_output, 3'h5);
    end_of_test();
  end
endmodule : tb
